// ---- hdl/ccc_card_supply_ctrl.sv ----
// Control logic of the smart card supply converter with APB registers
//
// Summary of operation
// R01: Converter stays off while the card is absent, whatever the enable bit.
// R02: Card removal while running starts an automatic shutdown sequence.
// R03: Supply enable bit set switches converter on; cleared switches it off.
// R04: Two-bit voltage select chooses the regulated card supply level.
// R05: Control bit 7: zero pump with inductor, one linear regulator.
// R06: Control bit 6 raises the overcurrent limit by twenty percent.
// R07: Overcurrent flag is set while the current limiter is active.
// R08: Boost field bits 5:4 step the startup current higher.
// R09: Boost also raises the overcurrent limit in the same proportion.
// R10: Software programs the prescaler for a 4 MHz converter clock; the largest divider here is 24, about 5.2 MHz from 125 MHz.
// R11: Software selects level, sets boost, enables, then polls ready.
// R12: Voltage ready flag is set once the supply reaches its level.
// R13: Software steps boost up until ready, then back down.
// R14: Software switches the converter off before power-down.
// R15: Voltage ready is cleared whenever the converter is off.
//
// Chosen here: the APB register port.
module ccc_card_supply_ctrl
  import ccc_pkg::*;
#(
  parameter int SHUT_CYCLES = SHUTDOWN_CYC
) (
  input  wire logic              CLK_SYS_IN,
  input  wire logic              RST_N_IN,
  input  wire logic              PSEL_IN,
  input  wire logic              PENABLE_IN,
  input  wire logic              PWRITE_IN,
  input  wire logic [APB_AW-1:0] PADDR_IN,
  input  wire logic [31:0]       PWDATA_IN,
  output logic      [31:0]       PRDATA_OUT,
  output logic                   PREADY_OUT,
  output logic                   PSLVERR_OUT,
  input  wire logic              CARD_PRESENT_IN,
  input  wire logic              LEVEL_REACHED_IN,
  input  wire logic              LIMITER_ACTIVE_IN,
  output ccc_drive_s             CONV_DRIVE_OUT,
  output logic                   CONV_CLK_TICK_OUT,
  output logic                   IRQ_OUT
);

  localparam int SC_W = $clog2(SHUT_CYCLES + 1);

  initial begin
    if (SHUT_CYCLES < 1) $error("SHUT_CYCLES must be at least 1");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ccc_state_e     st;
    ccc_conv_ctrl_s cctl;
    logic           supply_on;
    logic [1:0]     vsel;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [SC_W-1:0]  shut_cnt;
    logic           ready;
    logic           ovc;
    ccc_drive_s     drive;
    logic [31:0]    rdata;
  } ccc_regs_s;

  ccc_regs_s r_ff;
  ccc_regs_s nxt_r;

  // ----------------------------------------------------------------
  // Pin synchronisers and converter clock
  // ----------------------------------------------------------------
  logic [2:0] pins_sync;
  logic       present;
  logic       level_ok;
  logic       limiter;
  logic       conv_running;

  ccc_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_in   (CLK_SYS_IN),
    .rst_n_in (RST_N_IN),
    .async_in ({LIMITER_ACTIVE_IN, LEVEL_REACHED_IN, CARD_PRESENT_IN}),
    .sync_out (pins_sync)
  );

  assign present  = pins_sync[0];
  assign level_ok = pins_sync[1];
  assign limiter  = pins_sync[2];

  // Converter clock only runs while the stage is powered
  assign conv_running = (r_ff.st == CCC_START) || (r_ff.st == CCC_RUN);

  ccc_prescale u_prescale (
    .clk_in   (CLK_SYS_IN),
    .rst_n_in (RST_N_IN),
    .run_in   (conv_running),
    .code_in  (r_ff.cctl.prescale),
    .tick_out (CONV_CLK_TICK_OUT)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  function automatic logic [APB_AW-1:0] byte_addr(logic [7:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction

  logic setup_ph;
  logic wr_acc;
  logic hit_cctl;
  logic hit_card;
  logic hit_lvl;
  logic hit_st;
  logic hit_ist;
  logic hit_iclr;
  logic hit_ien;
  logic mapped;

  assign setup_ph = PSEL_IN && !PENABLE_IN;
  assign wr_acc   = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign hit_cctl = (PADDR_IN == byte_addr(IDX_CONV_CTRL));
  assign hit_card = (PADDR_IN == byte_addr(IDX_CARD_CTRL));
  assign hit_lvl  = (PADDR_IN == byte_addr(IDX_LEVEL_SEL));
  assign hit_st   = (PADDR_IN == byte_addr(IDX_STATUS));
  assign hit_ist  = (PADDR_IN == byte_addr(IDX_IRQ_STAT));
  assign hit_iclr = (PADDR_IN == byte_addr(IDX_IRQ_CLR));
  assign hit_ien  = (PADDR_IN == byte_addr(IDX_IRQ_EN));
  assign mapped   = hit_cctl || hit_card || hit_lvl || hit_st
                    || hit_ist || hit_iclr || hit_ien;

  // Zero wait states; unmapped addresses answer with an error
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;

  // Live card status as software sees it
  logic [7:0] status_word;
  always_comb begin
    status_word                 = '0;
    status_word[ST_READY_BIT]   = r_ff.ready;
    status_word[ST_OVC_BIT]     = r_ff.ovc;
    status_word[ST_PRESENT_BIT] = present;
    status_word[ST_SHUT_BIT]    = (r_ff.st == CCC_SHUT);
  end

  // Current limit in percent; boost scales it like the startup current
  function automatic logic [7:0] limit_pct(ccc_conv_ctrl_s c);
    logic [7:0] base;
    base = c.limit_raise ? LIMIT_BASE_PCT + LIMIT_RAISE_PCT
                         : LIMIT_BASE_PCT;                        // [R06]
    limit_pct = base + BOOST_STEP_PCT * {6'h00, c.boost};        // [R09]
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clr_mask;
  logic             removed;

  always_comb begin
    nxt_r    = r_ff;
    events   = '0;
    clr_mask = '0;
    removed  = 1'b0;

    // Register writes take effect in the access phase
    if (wr_acc && hit_cctl) begin
      nxt_r.cctl = ccc_conv_ctrl_s'(PWDATA_IN[7:0]);
    end else if (wr_acc && hit_card) begin
      nxt_r.supply_on = PWDATA_IN[CARD_CTRL_ON_BIT];
    end else if (wr_acc && hit_lvl) begin
      nxt_r.vsel = PWDATA_IN[1:0];
    end else if (wr_acc && hit_iclr) begin
      clr_mask = PWDATA_IN[IRQ_W-1:0];
    end else if (wr_acc && hit_ien) begin
      nxt_r.irq_en = PWDATA_IN[IRQ_W-1:0];
    end

    // Converter sequencer
    case (r_ff.st)
      CCC_OFF: begin
        nxt_r.shut_cnt = '0;
        if (r_ff.supply_on && present) begin                     // [R01] [R03]
          nxt_r.st = CCC_START;
        end
      end
      CCC_START: begin
        if (!present) begin                                      // [R02]
          removed  = 1'b1;
          nxt_r.st = CCC_SHUT;
        end else if (!r_ff.supply_on) begin                      // [R03]
          nxt_r.st = CCC_OFF;
        end else if (level_ok) begin                             // [R12]
          nxt_r.st = CCC_RUN;
          events[IRQ_READY_BIT] = 1'b1;
        end
      end
      CCC_RUN: begin
        if (!present) begin                                      // [R02]
          removed  = 1'b1;
          nxt_r.st = CCC_SHUT;
        end else if (!r_ff.supply_on) begin                      // [R03]
          nxt_r.st = CCC_OFF;
        end
      end
      CCC_SHUT: begin
        // Discharge for a fixed time before the stage may restart
        if (r_ff.shut_cnt == SC_W'(SHUT_CYCLES - 1)) begin
          nxt_r.st       = CCC_OFF;
          nxt_r.shut_cnt = '0;
        end else begin
          nxt_r.shut_cnt = r_ff.shut_cnt + 1'b1;
        end
      end
      default: nxt_r.st = CCC_OFF;
    endcase

    // Removal drops the enable so reinsertion needs software again
    if (removed) begin
      nxt_r.supply_on = 1'b0;                                    // [R02]
      events[IRQ_REMOVED_BIT] = 1'b1;
    end

    // Ready only in run; cleared in every other state
    nxt_r.ready = (nxt_r.st == CCC_RUN);                         // [R12] [R15]
    nxt_r.ovc   = limiter && conv_running;                       // [R07]
    events[IRQ_OVC_BIT] = nxt_r.ovc && !r_ff.ovc;

    // A new event wins over a clear in the same cycle
    nxt_r.irq_stat = (r_ff.irq_stat & ~clr_mask) | events;

    // Outputs to the power stage
    nxt_r.drive.enable      = (nxt_r.st == CCC_START)
                              || (nxt_r.st == CCC_RUN);          // [R01]
    nxt_r.drive.linear_mode = nxt_r.cctl.linear_mode;            // [R05]
    nxt_r.drive.volt_sel    = nxt_r.vsel;                        // [R04]
    nxt_r.drive.boost       = nxt_r.cctl.boost;                  // [R08]
    nxt_r.drive.limit_pct   = limit_pct(nxt_r.cctl);             // [R06] [R09]
    nxt_r.drive.discharge   = (nxt_r.st == CCC_SHUT);            // [R02]

    // Read data captured in the setup phase
    nxt_r.rdata = '0;
    if (setup_ph && !PWRITE_IN) begin
      if (hit_cctl) begin
        nxt_r.rdata[7:0] = r_ff.cctl;
      end else if (hit_card) begin
        nxt_r.rdata[CARD_CTRL_ON_BIT] = r_ff.supply_on;
      end else if (hit_lvl) begin
        nxt_r.rdata[1:0] = r_ff.vsel;
      end else if (hit_st) begin
        nxt_r.rdata[7:0] = status_word;
      end else if (hit_ist) begin
        nxt_r.rdata[IRQ_W-1:0] = r_ff.irq_stat;
      end else if (hit_ien) begin
        nxt_r.rdata[IRQ_W-1:0] = r_ff.irq_en;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      r_ff      <= '0;
      r_ff.st   <= CCC_OFF;
      r_ff.cctl <= ccc_conv_ctrl_s'(CONV_CTRL_RST);
      r_ff.vsel <= LEVEL_SEL_RST;
      r_ff.drive.limit_pct <= LIMIT_BASE_PCT;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign PRDATA_OUT     = r_ff.rdata;
  assign CONV_DRIVE_OUT = r_ff.drive;
  assign IRQ_OUT        = |(r_ff.irq_stat & r_ff.irq_en);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_absent_off: assert property (@(posedge CLK_SYS_IN) // [R01]
    disable iff (!RST_N_IN)
    !present |=> !CONV_DRIVE_OUT.enable)
    else $error("converter enabled while card absent");

  chk_removal_shut: assert property (@(posedge CLK_SYS_IN) // [R02]
    disable iff (!RST_N_IN)
    (conv_running && !present) |=>
      (CONV_DRIVE_OUT.discharge && !r_ff.supply_on))
    else $error("card removal did not start shutdown");

  chk_enable_start: assert property (@(posedge CLK_SYS_IN) // [R03]
    disable iff (!RST_N_IN)
    (r_ff.st == CCC_OFF && r_ff.supply_on && present) |=>
      CONV_DRIVE_OUT.enable ##0 (r_ff.st == CCC_START))
    else $error("enable bit did not start converter");

  chk_disable_off: assert property (@(posedge CLK_SYS_IN) // [R03]
    disable iff (!RST_N_IN)
    (conv_running && present && !r_ff.supply_on) |=>
      !CONV_DRIVE_OUT.enable)
    else $error("clearing enable did not stop converter");

  chk_level_mode: assert property (@(posedge CLK_SYS_IN) // [R04]
    disable iff (!RST_N_IN)
    ##1 (CONV_DRIVE_OUT.volt_sel == $past(nxt_r.vsel))
      && (CONV_DRIVE_OUT.linear_mode == $past(nxt_r.cctl.linear_mode)))
    else $error("level or mode not driven to power stage");

  chk_limit_pct: assert property (@(posedge CLK_SYS_IN) // [R06]
    disable iff (!RST_N_IN)
    (wr_acc && hit_cctl && PWDATA_IN[7:4] == 4'h6) |=>
      (CONV_DRIVE_OUT.limit_pct == 8'h8C && CONV_DRIVE_OUT.boost == 2'h2))
    else $error("limit not raised by 20 plus boost steps");

  chk_ovc_flag: assert property (@(posedge CLK_SYS_IN) // [R07]
    disable iff (!RST_N_IN)
    (limiter && conv_running) |=> status_word[ST_OVC_BIT])
    else $error("overcurrent flag missing");

  chk_ready_set: assert property (@(posedge CLK_SYS_IN) // [R12]
    disable iff (!RST_N_IN)
    (r_ff.st == CCC_START && present && r_ff.supply_on && level_ok)
      |=> (r_ff.ready && r_ff.irq_stat[IRQ_READY_BIT]))
    else $error("ready flag not set on reaching level");

  chk_ready_off: assert property (@(posedge CLK_SYS_IN) // [R15]
    disable iff (!RST_N_IN)
    !CONV_DRIVE_OUT.enable |-> !r_ff.ready)
    else $error("ready flag set while converter off");

  // Shutdown ends and discharge stops once the full discharge time has passed
  chk_shut_done: assert property (@(posedge CLK_SYS_IN) // [R02]
    disable iff (!RST_N_IN)
    (r_ff.st == CCC_SHUT && r_ff.shut_cnt == SC_W'(SHUT_CYCLES - 1)) |=>
      (r_ff.st == CCC_OFF && !CONV_DRIVE_OUT.discharge))
    else $error("shutdown did not end after discharge time");

  chk_absent_hold: assert property (@(posedge CLK_SYS_IN) // [R01]
    disable iff (!RST_N_IN)
    (r_ff.st == CCC_OFF && !present) |=> (r_ff.st == CCC_OFF))
    else $error("sequencer left off state with card absent");

endmodule

// ---- hdl/ccc_pkg.sv ----
// Constants, register map and shared types of the card supply converter
package ccc_pkg;

  // ----------------------------------------------------------------
  // Register map (printed offsets are indices, byte address = 4 x)
  // ----------------------------------------------------------------
  localparam int         APB_AW        = 12;
  localparam logic [7:0] IDX_CONV_CTRL = 8'hBF;
  localparam logic [7:0] IDX_CARD_CTRL = 8'hC0;
  localparam logic [7:0] IDX_LEVEL_SEL = 8'hC1;
  localparam logic [7:0] IDX_STATUS    = 8'hC2;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'hC3;
  localparam logic [7:0] IDX_IRQ_CLR   = 8'hC4;
  localparam logic [7:0] IDX_IRQ_EN    = 8'hC5;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         CARD_CTRL_ON_BIT = 0;
  localparam logic [7:0] CONV_CTRL_RST    = 8'h00;
  localparam logic [1:0] LEVEL_SEL_RST    = 2'h0;
  localparam int         ST_READY_BIT     = 0;
  localparam int         ST_OVC_BIT       = 1;
  localparam int         ST_PRESENT_BIT   = 2;
  localparam int         ST_SHUT_BIT      = 3;
  localparam int         IRQ_W            = 3;
  localparam int         IRQ_READY_BIT    = 0;
  localparam int         IRQ_OVC_BIT      = 1;
  localparam int         IRQ_REMOVED_BIT  = 2;

  // ----------------------------------------------------------------
  // Current limit in percent of the nominal limit
  // ----------------------------------------------------------------
  localparam logic [7:0] LIMIT_BASE_PCT  = 8'h64;  // 100 percent
  localparam logic [7:0] LIMIT_RAISE_PCT = 8'h14;  // plus 20 percent
  localparam logic [7:0] BOOST_STEP_PCT  = 8'h0A;  // plus 10 per step

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 8;
  localparam int SHUTDOWN_NS    = 1000;
  localparam int SHUTDOWN_CYC   = (SHUTDOWN_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int PS_CNT_W       = 5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CCC_OFF   = 2'b00,
    CCC_START = 2'b01,
    CCC_RUN   = 2'b10,
    CCC_SHUT  = 2'b11
  } ccc_state_e;

  // Same bit order as the converter control register
  typedef struct packed {
    logic       linear_mode;
    logic       limit_raise;
    logic [1:0] boost;
    logic [3:0] prescale;
  } ccc_conv_ctrl_s;

  // Drive towards the analog power stage
  typedef struct packed {
    logic       enable;
    logic       linear_mode;
    logic [1:0] volt_sel;
    logic [1:0] boost;
    logic [7:0] limit_pct;
    logic       discharge;
  } ccc_drive_s;

endpackage

// ---- hdl/ccc_prescale.sv ----
// Converter clock divider producing a one-cycle enable pulse
module ccc_prescale
  import ccc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       run_in,
  input  wire logic [3:0] code_in,
  output logic            tick_out
);

  // Division factor per prescale code; codes 9 and above use the largest
  function automatic logic [PS_CNT_W-1:0] div_factor(logic [3:0] c);
    case (c)
      4'h0:    div_factor = 5'h02;
      4'h1:    div_factor = 5'h03;
      4'h2:    div_factor = 5'h04;
      4'h3:    div_factor = 5'h05;
      4'h4:    div_factor = 5'h06;
      4'h5:    div_factor = 5'h07;
      4'h6:    div_factor = 5'h08;
      4'h7:    div_factor = 5'h0A;
      4'h8:    div_factor = 5'h0C;
      default: div_factor = 5'h18;
    endcase
  endfunction

  typedef struct packed {
    logic [PS_CNT_W-1:0] cnt;
    logic                tick;
  } ccc_ps_s;

  ccc_ps_s r_ff;
  ccc_ps_s nxt_r;
  logic    last;

  // Counter restarts whenever the converter stops
  always_comb begin
    last       = (r_ff.cnt >= div_factor(code_in) - 5'h01);
    nxt_r.cnt  = (!run_in || last) ? '0 : r_ff.cnt + 5'h01;
    nxt_r.tick = run_in && last;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) r_ff <= '0;
    else           r_ff <= nxt_r;
  end

  assign tick_out = r_ff.tick;

endmodule

// ---- hdl/ccc_sync.sv ----
// Two-stage synchroniser for pin inputs
module ccc_sync
  import ccc_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  initial begin
    if (WIDTH < 1) $error("ccc_sync: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ccc_sync_s;

  ccc_sync_s r_ff;
  ccc_sync_s nxt_r;

  // First stage feeds only the second stage
  always_comb begin
    nxt_r.meta   = async_in;
    nxt_r.stable = r_ff.meta;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) r_ff <= '0;
    else           r_ff <= nxt_r;
  end

  assign sync_out = r_ff.stable;

endmodule

// ---- sim/ccc_stage_model.sv ----
// Behavioural model of the analog power stage that feeds the card supply
module ccc_stage_model
  import ccc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire ccc_drive_s drive_in,
  input  wire logic [1:0] need_boost_in,
  input  wire logic [7:0] delay_in,
  input  wire logic       short_in,
  output logic            level_out,
  output logic            limiter_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] ramp_ff;

  // ----------------------------------------------------------------
  // Supply ramp
  // ----------------------------------------------------------------
  // Too little startup current never reaches the level, so software
  // has to step the boost up; once reached, the level holds even when
  // boost is lowered again, until the stage is switched off
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !drive_in.enable) begin
      ramp_ff   <= 8'h00;
      level_out <= 1'b0;
    end else begin
      if (drive_in.boost >= need_boost_in && ramp_ff != delay_in)
        ramp_ff <= ramp_ff + 8'h01;
      level_out <= level_out || (ramp_ff == delay_in);
    end
  end

  // Limiter only acts while the stage is running into a short
  assign limiter_out = drive_in.enable & short_in;
endmodule

// ---- sim/test_card_supply_converter_ctrl.sv ----
// Self-checking testbench of the card supply converter control block
module test_card_supply_converter_ctrl
  import ccc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SHUT = 8;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        card = 1'b0;
  logic        level;
  logic        limiter;
  ccc_drive_s  drive;
  logic        tick;
  logic        irq;
  logic [1:0]  need = 2'h0;
  logic [7:0]  dly = 8'h05;
  logic        short = 1'b0;
  logic [31:0] rdat;
  logic        last_err;
  int          err_total = 0;
  int          checks = 0;

  ccc_card_supply_ctrl #(.SHUT_CYCLES(SHUT)) dut (
    .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .CARD_PRESENT_IN(card),
    .LEVEL_REACHED_IN(level), .LIMITER_ACTIVE_IN(limiter),
    .CONV_DRIVE_OUT(drive), .CONV_CLK_TICK_OUT(tick), .IRQ_OUT(irq));

  ccc_stage_model stage (
    .clk_in(clk), .rst_n_in(rst_n), .drive_in(drive),
    .need_boost_in(need), .delay_in(dly), .short_in(short),
    .level_out(level), .limiter_out(limiter));

  // 125 MHz system clock
  always #4 clk = ~clk;

  // ----------------------------------------------------------------
  // Bus, compare and expectation helpers
  // ----------------------------------------------------------------
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx);
    apb(1'b0, idx, 32'h0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Cycles between two converter clock ticks, bounded
  task automatic period(output int n);
    int k;
    for (k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (tick !== 1'b1 && n < 40);
    end
  endtask

  function automatic logic [7:0] lim(input logic [7:0] v);
    return LIMIT_BASE_PCT + (v[6] ? LIMIT_RAISE_PCT : 8'h00)
           + BOOST_STEP_PCT * v[5:4];
  endfunction

  function automatic int fac(input logic [3:0] c);
    if (c < 4'h7)
      return c + 2;
    if (c == 4'h7)
      return 10;
    if (c == 4'h8)
      return 12;
    return 24;
  endfunction

  task automatic finish_test;
    if (err_total == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog well beyond the expected run of roughly a thousand cycles
  initial begin
    #320000;
    err_total++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic [1:0] sel;
    int b;
    int n;
    void'($urandom(96376));
    cyc(12);
    rst_n <= 1'b1;
    rd(IDX_CONV_CTRL);
    chk(rdat, 32'(CONV_CTRL_RST));
    chk(drive.limit_pct, LIMIT_BASE_PCT);
    // Control fields: corners first, then random values
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hF0 : ((i == 1) ? 8'h40 : 8'($urandom));
      // Raise plus boost two, the case the limit assertion watches
      if (i == 2)
        v = 8'h6B;
      wr(IDX_CONV_CTRL, {24'h0, v});
      rd(IDX_CONV_CTRL);
      chk(rdat, {24'h0, v});
      chk(drive.linear_mode, v[7]);
      chk(drive.boost, v[5:4]);
      chk(drive.limit_pct, lim(v));
    end
    // Enable with no card must not start the stage
    wr(IDX_CONV_CTRL, 32'h0);
    wr(IDX_CARD_CTRL, 32'h1);
    cyc(6);
    chk(drive.enable, 1'b0);
    wr(IDX_CARD_CTRL, 32'h0);
    card <= 1'b1;
    need <= 2'($urandom);
    dly <= 8'(5 + $urandom % 20);
    sel = 2'($urandom);
    cyc(4);
    // Start-up: level, boost, enable, poll; boost stepped until ready
    wr(IDX_IRQ_EN, 32'h7);
    wr(IDX_LEVEL_SEL, {30'h0, sel});
    for (b = 0; b < 4; b++) begin
      wr(IDX_CONV_CTRL, {26'h0, 2'(b), 4'h0});
      if (b == 0)
        wr(IDX_CARD_CTRL, 32'h1);
      cyc(40);
      rd(IDX_STATUS);
      if (rdat[ST_READY_BIT] === 1'b1)
        break;
    end
    chk(b, 32'(need));
    chk(drive.enable, 1'b1);
    chk(drive.volt_sel, sel);
    chk(irq, 1'b1);
    wr(IDX_CONV_CTRL, 32'h0);
    cyc(3);
    chk(drive.limit_pct, LIMIT_BASE_PCT);
    // Converter clock divider for every code
    for (int c = 0; c < 16; c++) begin
      wr(IDX_CONV_CTRL, 32'(c));
      period(n);
      chk(n, fac(4'(c)));
    end
    // Overcurrent, interrupt mask and clear
    short <= 1'b1;
    cyc(6);
    rd(IDX_STATUS);
    chk(rdat[ST_OVC_BIT], 1'b1);
    chk(rdat[ST_PRESENT_BIT], 1'b1);
    rd(IDX_IRQ_STAT);
    chk(rdat[2:0], 3'b011);
    wr(IDX_IRQ_EN, 32'h0);
    cyc(1);
    chk(irq, 1'b0);
    wr(IDX_IRQ_CLR, 32'h7);
    rd(IDX_IRQ_STAT);
    chk(rdat, 32'h0);
    short <= 1'b0;
    rd(8'h10);
    chk(last_err, 1'b1);
    // Software switch-off clears ready
    wr(IDX_CARD_CTRL, 32'h0);
    cyc(3);
    chk(drive.enable, 1'b0);
    rd(IDX_STATUS);
    chk(rdat[ST_READY_BIT], 1'b0);
    // Card removed while running
    wr(IDX_CONV_CTRL, {26'h0, need, 4'h0});
    wr(IDX_IRQ_EN, 32'h4);
    wr(IDX_CARD_CTRL, 32'h1);
    cyc(40);
    card <= 1'b0;
    cyc(5);
    chk({drive.enable, drive.discharge}, 2'b01);
    rd(IDX_STATUS);
    chk(rdat[ST_SHUT_BIT], 1'b1);
    cyc(20);
    chk(drive.discharge, 1'b0);
    rd(IDX_CARD_CTRL);
    chk(rdat, 32'h0);
    rd(IDX_STATUS);
    chk(rdat[ST_READY_BIT], 1'b0);
    chk(rdat[ST_PRESENT_BIT], 1'b0);
    chk(irq, 1'b1);
    wr(IDX_IRQ_CLR, 32'h4);
    cyc(1);
    chk(irq, 1'b0);
    finish_test();
  end
endmodule
